// >>> design/level_sync.v
// Purpose: Two flip-flop synchroniser for a bundle of pin levels
// Assumes: Each bit is an independent level
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter WIDTH = 1
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// >>> design/phase_map_detect.v
// Purpose: Builds the SYSREF position map from per-tap samples
// Assumes: Samples and edge pulse already synchronised
// Notes: Map refreshes every cycle without a SYSREF rise, once three edges are captured
`timescale 1ns/1ps
`default_nettype none
`include "sysref_window_autocal_defs.vh"
module phase_map_detect #(
  parameter POSITIONS = `MAP_POSITIONS
) (
  input wire hclk,
  input wire hresetn,
  input wire sysref_rise,
  input wire restart,
  input wire [POSITIONS-1:0] tap_samples,
  output wire [POSITIONS-1:0] sysref_phase_map,
  output wire map_valid
);
  reg [POSITIONS-1:0] cap0_r;
  reg [POSITIONS-1:0] cap1_r;
  reg [POSITIONS-1:0] cap2_r;
  reg [POSITIONS-1:0] map_r;
  reg [1:0] edge_cnt_r;
  wire [POSITIONS-1:0] risk;

  // Unstable across edges or next to a transition
  genvar i;
  generate
    for (i = 1; i < POSITIONS - 1; i = i + 1) begin : g_pos
      assign risk[i] = (cap0_r[i] != cap1_r[i]) | (cap1_r[i] != cap2_r[i]) |
                       (cap0_r[i] != cap0_r[i-1]) | (cap0_r[i] != cap0_r[i+1]);
    end
  endgenerate
  assign risk[0] = 1'b1;
  assign risk[POSITIONS-1] = 1'b1;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap0_r <= {POSITIONS{1'b0}};
      cap1_r <= {POSITIONS{1'b0}};
      cap2_r <= {POSITIONS{1'b0}};
      map_r <= {POSITIONS{1'b1}};
      edge_cnt_r <= 2'd0;
    end else if (restart) begin
      edge_cnt_r <= 2'd0;
    end else if (sysref_rise) begin
      // Shift in samples from the newest edge
      cap0_r <= tap_samples;
      cap1_r <= cap0_r;
      cap2_r <= cap1_r;
      if (edge_cnt_r != `MAP_EDGES_VALID) begin
        edge_cnt_r <= edge_cnt_r + 2'd1;
      end
    end else if (edge_cnt_r == `MAP_EDGES_VALID) begin
      map_r <= risk;
    end
  end

  assign sysref_phase_map = map_r;
  assign map_valid = (edge_cnt_r == `MAP_EDGES_VALID);
endmodule
`default_nettype wire

// >>> design/sysref_window_autocal.v
// Purpose: SYSREF windowing detector and automatic alignment calibration
// Assumes: Single clock hclk; pins from the clock source are asynchronous
// Notes: Registers reached over a zero-wait AHB-Lite slave
//
// Summary of operation
// - Map SYSREF phase over 24 positions; valid after three SYSREF rises.
// - Map bit is 1 at risky positions, 0 at usable ones.
// - Capture tap value is the map bit index; SYSREF captured there.
// - Capture tap reaches only positions 0 to 15.
// - Map bits 0 and 23 always read 1.
// - Step control: 0 coarse spacing, 1 fine spacing.
// - Enabled search steps delays until clock falling edge meets SYSREF rise.
// - Completion flag raised in status when search ends.
// - Found setting readable and kept applied while enable stays set.
// - Coarse search with inversion off and on; smallest coarse wins.
// - Inversion adds half a clock period to all clocks.
// - Coarse and fine delays each have 256 settings.
`timescale 1ns/1ps
`default_nettype none
`include "sysref_window_autocal_defs.vh"
module sysref_window_autocal #(
  parameter POSITIONS = `MAP_POSITIONS
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire sysref_pin,
  input wire [POSITIONS-1:0] tap_samples,
  input wire align_compare,
  output reg sysref_captured,
  output wire [3:0] sysref_capture_tap,
  output wire phase_step_fine,
  output reg clock_invert_delay,
  output reg [7:0] coarse_delay,
  output reg [7:0] fine_delay
);
  localparam ST_IDLE = 3'd0;
  localparam ST_CSET = 3'd1;
  localparam ST_CWAIT = 3'd2;
  localparam ST_CCHK = 3'd3;
  localparam ST_FSET = 3'd4;
  localparam ST_FWAIT = 3'd5;
  localparam ST_FCHK = 3'd6;
  localparam ST_DONE = 3'd7;

  // Synchronised pins
  wire sysref_s;
  wire align_s;
  wire [POSITIONS-1:0] taps_s;
  level_sync #(.WIDTH(POSITIONS + 2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({align_compare, sysref_pin, tap_samples}),
    .sync_out({align_s, sysref_s, taps_s})
  );

  reg sysref_d_r;
  wire sysref_rise = sysref_s & ~sysref_d_r;

  // Registers
  reg [4:0] clock_ctrl_r;
  reg [7:0] align_cal_config_r;
  reg align_cal_enable_r;
  reg align_cal_finished_r;
  reg [16:0] align_cal_result_r;
  reg [16:0] tad_manual_r;
  wire [POSITIONS-1:0] sysref_phase_map;
  wire map_valid;
  wire step_change;

  assign sysref_capture_tap = clock_ctrl_r[`CTRL_TAP_MSB:`CTRL_TAP_LSB];
  assign phase_step_fine = clock_ctrl_r[`CTRL_FINE_BIT];

  phase_map_detect #(.POSITIONS(POSITIONS)) u_map (
    .hclk(hclk),
    .hresetn(hresetn),
    .sysref_rise(sysref_rise),
    .restart(step_change),
    .tap_samples(taps_s),
    .sysref_phase_map(sysref_phase_map),
    .map_valid(map_valid)
  );

  // Bus slave
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  reg wr_pend_r;
  reg [7:0] wr_idx_r;
  wire addr_phase = hsel & hready & htrans[1];
  wire [7:0] a_idx = reg_index(haddr);
  wire wr_ctrl = wr_pend_r & (wr_idx_r == `IDX_CLOCK_CTRL);
  wire wr_cfg = wr_pend_r & (wr_idx_r == `IDX_CAL_CONFIG);
  wire wr_en = wr_pend_r & (wr_idx_r == `IDX_CAL_ENABLE);
  wire wr_tad = wr_pend_r & (wr_idx_r == `IDX_TAD_MANUAL);
  assign step_change = wr_ctrl & (hwdata[`CTRL_FINE_BIT] != clock_ctrl_r[`CTRL_FINE_BIT]);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  reg [31:0] rd_nxt;
  reg [2:0] state_r;
  always @* begin
    case (a_idx)
      `IDX_PHASE_MAP_LOW: rd_nxt = {24'h00_0000, sysref_phase_map[7:0]};
      `IDX_PHASE_MAP_MID: rd_nxt = {24'h00_0000, sysref_phase_map[15:8]};
      `IDX_PHASE_MAP_HIGH: rd_nxt = {24'h00_0000, sysref_phase_map[23:16]};
      `IDX_CLOCK_CTRL: rd_nxt = {27'h000_0000, clock_ctrl_r};
      `IDX_CAL_CONFIG: rd_nxt = {24'h00_0000, align_cal_config_r};
      `IDX_CAL_ENABLE: rd_nxt = {31'h0000_0000, align_cal_enable_r};
      `IDX_CAL_STATUS: rd_nxt = {29'h0000_0000, (state_r != ST_IDLE) & (state_r != ST_DONE),
                                 map_valid, align_cal_finished_r};
      `IDX_CAL_RESULT: rd_nxt = {15'h0000, align_cal_result_r};
      `IDX_TAD_MANUAL: rd_nxt = {15'h0000, tad_manual_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      wr_idx_r <= a_idx;
      if (addr_phase & ~hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_ctrl_r <= `RST_CLOCK_CTRL;
      align_cal_config_r <= `RST_CAL_CONFIG;
      align_cal_enable_r <= 1'b0;
      tad_manual_r <= `RST_TAD_MANUAL;
    end else begin
      if (wr_ctrl) begin
        clock_ctrl_r <= hwdata[4:0];
      end
      if (wr_cfg) begin
        align_cal_config_r <= hwdata[7:0];
      end
      if (wr_en) begin
        align_cal_enable_r <= hwdata[0];
      end
      if (wr_tad) begin
        tad_manual_r <= hwdata[16:0];
      end
    end
  end

  // SYSREF capture on the selected delayed instance
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysref_d_r <= 1'b0;
      sysref_captured <= 1'b0;
    end else begin
      sysref_d_r <= sysref_s;
      sysref_captured <= taps_s[sysref_capture_tap];
    end
  end

  // Calibration search
  reg en_d_r;
  reg inv_r;
  reg [7:0] coarse_r;
  reg [7:0] fine_r;
  reg [8:0] wait_r;
  reg found0_r;
  reg [7:0] best0_r;
  wire cal_start = align_cal_enable_r & ~en_d_r;
  wire [8:0] settle = {1'b0, align_cal_config_r} + {1'b0, `SYNC_LATENCY};
  wire last_coarse = (coarse_r == 8'hff);
  wire use_inv = found0_r ? 1'b0 : 1'b1;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      en_d_r <= 1'b0;
      inv_r <= 1'b0;
      coarse_r <= 8'h00;
      fine_r <= 8'h00;
      wait_r <= 9'h000;
      found0_r <= 1'b0;
      best0_r <= 8'hff;
      align_cal_finished_r <= 1'b0;
      align_cal_result_r <= 17'h0_0000;
    end else begin
      en_d_r <= align_cal_enable_r;
      if (cal_start) begin
        state_r <= ST_CSET;
        inv_r <= 1'b0;
        coarse_r <= 8'h00;
        fine_r <= 8'h00;
        found0_r <= 1'b0;
        best0_r <= 8'hff;
        align_cal_finished_r <= 1'b0;
      end else if (!align_cal_enable_r && state_r != ST_DONE) begin
        state_r <= ST_IDLE;
      end else begin
        case (state_r)
          ST_IDLE: begin
            state_r <= ST_IDLE;
          end
          ST_CSET: begin
            wait_r <= settle;
            state_r <= ST_CWAIT;
          end
          ST_CWAIT: begin
            if (wait_r == 9'h000) begin
              state_r <= ST_CCHK;
            end else begin
              wait_r <= wait_r - 9'h001;
            end
          end
          ST_CCHK: begin
            // Falling edge has reached the SYSREF rise at this coarse step, or coarse is at its last step
            if (align_s || last_coarse) begin
              if (!inv_r) begin
                found0_r <= align_s;
                best0_r <= coarse_r;
                inv_r <= 1'b1;
                coarse_r <= 8'h00;
                state_r <= ST_CSET;
              end else begin
                // Keep whichever polarity needs the smaller coarse step
                if (found0_r && (!align_s || best0_r <= coarse_r)) begin
                  inv_r <= 1'b0;
                  coarse_r <= (best0_r == 8'h00) ? 8'h00 : best0_r - 8'h01;
                end else begin
                  coarse_r <= (coarse_r == 8'h00) ? 8'h00 : coarse_r - 8'h01;
                end
                fine_r <= 8'h00;
                state_r <= ST_FSET;
              end
            end else begin
              coarse_r <= coarse_r + 8'h01;
              state_r <= ST_CSET;
            end
          end
          ST_FSET: begin
            wait_r <= settle;
            state_r <= ST_FWAIT;
          end
          ST_FWAIT: begin
            if (wait_r == 9'h000) begin
              state_r <= ST_FCHK;
            end else begin
              wait_r <= wait_r - 9'h001;
            end
          end
          ST_FCHK: begin
            if (align_s || fine_r == 8'hff) begin
              align_cal_result_r <= {inv_r, coarse_r, fine_r};
              align_cal_finished_r <= 1'b1;
              state_r <= ST_DONE;
            end else begin
              fine_r <= fine_r + 8'h01;
              state_r <= ST_FSET;
            end
          end
          ST_DONE: begin
            state_r <= ST_DONE;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Delay drive: search value, held result, or manual setting
  wire searching = (state_r != ST_IDLE) & (state_r != ST_DONE);
  wire hold_result = (state_r == ST_DONE) & align_cal_enable_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_invert_delay <= 1'b0;
      coarse_delay <= 8'h00;
      fine_delay <= 8'h00;
    end else if (searching) begin
      clock_invert_delay <= inv_r;
      coarse_delay <= coarse_r;
      fine_delay <= fine_r;
    end else if (hold_result) begin
      clock_invert_delay <= align_cal_result_r[`CLOCK_INVERT_DELAY_BIT];
      coarse_delay <= align_cal_result_r[`COARSE_DELAY_LSB+7:`COARSE_DELAY_LSB];
      fine_delay <= align_cal_result_r[`FINE_DELAY_LSB+7:`FINE_DELAY_LSB];
    end else begin
      clock_invert_delay <= tad_manual_r[`CLOCK_INVERT_DELAY_BIT];
      coarse_delay <= tad_manual_r[`COARSE_DELAY_LSB+7:`COARSE_DELAY_LSB];
      fine_delay <= tad_manual_r[`FINE_DELAY_LSB+7:`FINE_DELAY_LSB];
    end
  end

  wire unused_ok = &{1'b0, hsize, haddr[31:10], haddr[1:0], htrans[0], use_inv, hwdata[31:17]};
endmodule
`default_nettype wire

// >>> design/sysref_window_autocal_defs.vh
// Purpose: Shared offsets, fields, resets and counts of the SYSREF capture block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: Byte address of a register is four times its index
`ifndef SYSREF_WINDOW_AUTOCAL_DEFS_VH
`define SYSREF_WINDOW_AUTOCAL_DEFS_VH

// Register indexes
`define IDX_PHASE_MAP_LOW 8'h2c
`define IDX_PHASE_MAP_MID 8'h2d
`define IDX_PHASE_MAP_HIGH 8'h2e
`define IDX_CLOCK_CTRL 8'h30
`define IDX_CAL_CONFIG 8'h31
`define IDX_CAL_ENABLE 8'h32
`define IDX_CAL_STATUS 8'h33
`define IDX_CAL_RESULT 8'h34
`define IDX_TAD_MANUAL 8'h35

// Clock control fields
`define CTRL_TAP_LSB 0
`define CTRL_TAP_MSB 3
`define CTRL_FINE_BIT 4
// Status fields
`define STAT_DONE_BIT 0
`define STAT_VALID_BIT 1
`define STAT_BUSY_BIT 2
// Delay word fields: {invert, coarse, fine}
`define FINE_DELAY_LSB 0
`define COARSE_DELAY_LSB 8
`define CLOCK_INVERT_DELAY_BIT 16

// Reset values
`define RST_CLOCK_CTRL 5'h10
`define RST_CAL_CONFIG 8'h10
`define RST_TAD_MANUAL 17'h0_0000

// Map geometry and timing
`define MAP_POSITIONS 24
`define MAP_EDGES_VALID 2'd3
`define SYNC_LATENCY 8'd3
`define DELAY_SETTINGS 256

`endif

// >>> sim/sysref_source.sv
// Purpose: Clock source model for SYSREF, tap samples and alignment
// Assumes: Tap pattern fixed by SYSREF phase against the clock
// Notes: SYSREF stands low while run is low
`timescale 1ns/1ps
`default_nettype none
module sysref_source (
  input wire logic run,
  input wire logic [4:0] edge_pos,
  input wire logic [15:0] target0,
  input wire logic [15:0] target1,
  input wire logic clock_invert_delay,
  input wire logic [7:0] coarse_delay,
  input wire logic [7:0] fine_delay,
  output logic sysref_pin,
  output logic [23:0] tap_samples,
  output logic align_compare
);
  // Periodic SYSREF, unrelated in phase to the clock
  initial begin
    sysref_pin = 1'b0;
    forever begin
      #23.3;
      sysref_pin = run ? !sysref_pin : 1'b0;
    end
  end
  // Taps past the edge see SYSREF high
  assign tap_samples = 24'hff_ffff << edge_pos;
  // Aligned once the total delay reaches the target
  assign align_compare = ({coarse_delay, fine_delay} >=
    (clock_invert_delay ? target1 : target0));
endmodule
`default_nettype wire

// >>> sim/sysref_window_autocal_sva.sv
// Purpose: Port assertions for the SYSREF capture block
// Assumes: Zero-wait AHB-Lite slave, byte address four times the index
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module sysref_window_autocal_sva #(
  parameter POSITIONS = 24
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sysref_pin,
  input wire logic [POSITIONS-1:0] tap_samples,
  input wire logic align_compare,
  input wire logic sysref_captured,
  input wire logic [3:0] sysref_capture_tap,
  input wire logic phase_step_fine,
  input wire logic clock_invert_delay,
  input wire logic [7:0] coarse_delay,
  input wire logic [7:0] fine_delay
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd, wr;
  logic [7:0] idx;
  logic [3:0] calm_r;
  logic [POSITIONS-1:0] taps_r;
  logic [3:0] tap_r;
  assign idx = haddr[9:2];
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign wr = hsel && hready && htrans[1] && hwrite;
  // Cycles since samples or tap last moved
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      calm_r <= 4'h0;
      taps_r <= '0;
      tap_r <= 4'h0;
    end else begin
      taps_r <= tap_samples;
      tap_r <= sysref_capture_tap;
      if (taps_r != tap_samples || tap_r != sysref_capture_tap) begin
        calm_r <= 4'h0;
      end else if (calm_r != 4'hf) begin
        calm_r <= calm_r + 4'h1;
      end
    end
  end
  AST_MAP_LOW_EDGE:
    assert property (rd && idx == 8'h2c |=> hrdata[0] && hrdata[31:8] == 24'h00_0000)
    else $error("map bit 0 clear");
  AST_MAP_HIGH_EDGE:
    assert property (rd && idx == 8'h2e |=> hrdata[7] && hrdata[31:8] == 24'h00_0000)
    else $error("map bit 23 clear");
  AST_TAP_WRITE:
    assert property (wr && idx == 8'h30 |=> ##1 sysref_capture_tap == $past(hwdata[3:0]))
    else $error("tap not taken");
  AST_STEP_WRITE:
    assert property (wr && idx == 8'h30 ##1 1'b1 |=> phase_step_fine == $past(hwdata[4]))
    else $error("step not taken");
  AST_CTRL_READBACK:
    assert property (rd && idx == 8'h30 && !$past(wr) |=>
      hrdata == {27'h000_0000, phase_step_fine, sysref_capture_tap})
    else $error("control readback");
  AST_CAPTURE_TAP:
    assert property (calm_r > 4'h5 && taps_r == tap_samples && tap_r == sysref_capture_tap |->
      sysref_captured == tap_samples[sysref_capture_tap])
    else $error("capture tap");
  AST_STATUS_FIELDS:
    assert property (rd && idx == 8'h33 |=> hrdata[31:3] == 29'h0000_0000)
    else $error("status width");
  AST_RESULT_FIELDS:
    assert property (rd && idx == 8'h34 |=> hrdata[31:17] == 15'h0000)
    else $error("result width");
  cover property (wr && idx == 8'h32);
  cover property (rd && idx == 8'h34);
  cover property (calm_r == 4'hf && sysref_captured);
endmodule
bind sysref_window_autocal sysref_window_autocal_sva #(.POSITIONS(POSITIONS)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sysref_pin(sysref_pin),
  .tap_samples(tap_samples), .align_compare(align_compare),
  .sysref_captured(sysref_captured), .sysref_capture_tap(sysref_capture_tap),
  .phase_step_fine(phase_step_fine), .clock_invert_delay(clock_invert_delay),
  .coarse_delay(coarse_delay), .fine_delay(fine_delay));
`default_nettype wire

// >>> sim/tb_sysref_window_autocal.sv
// Purpose: Self-checking bench for the SYSREF capture block
// Assumes: Read data stands in the data phase
// Notes: Reads queue an expected word and mask for the monitor
`timescale 1ns/1ps
`default_nettype none
`include "sysref_window_autocal_defs.vh"
module tb_sysref_window_autocal;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sysref_pin, align_compare, sysref_captured, phase_step_fine;
  logic clock_invert_delay;
  logic [23:0] tap_samples;
  logic [3:0] sysref_capture_tap;
  logic [7:0] coarse_delay, fine_delay;
  logic run = 1'b0;
  logic [4:0] edge_pos = 5'h08;
  logic [31:0] exp_q[$], msk_q[$];
  logic dph = 1'b0;
  logic [31:0] seed = 32'h0001_299d;
  int errors = 0;
  int num_checks = 0;
  always #2 hclk = ~hclk;
  sysref_window_autocal dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sysref_pin(sysref_pin),
    .tap_samples(tap_samples), .align_compare(align_compare),
    .sysref_captured(sysref_captured), .sysref_capture_tap(sysref_capture_tap),
    .phase_step_fine(phase_step_fine), .clock_invert_delay(clock_invert_delay),
    .coarse_delay(coarse_delay), .fine_delay(fine_delay));
  sysref_source u_src (.run(run), .edge_pos(edge_pos), .target0(16'h0305),
    .target1(16'h0122), .clock_invert_delay(clock_invert_delay),
    .coarse_delay(coarse_delay), .fine_delay(fine_delay), .sysref_pin(sysref_pin),
    .tap_samples(tap_samples), .align_compare(align_compare));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
    end
  endfunction
  task automatic report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    begin
      num_checks++;
      if (((got ^ exp) & m) !== 32'h0000_0000) begin
        errors++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Monitor: compare read data in its data phase
  always @(posedge hclk) begin
    if (dph === 1'b1 && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front(), msk_q.pop_front());
    dph <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  task automatic wait_rdy;
    int n;
    begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
        errors++;
        $display("[ERR] %0t ready wait timed out", $time);
        report_and_stop();
      end
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
    input logic [31:0] m);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h00_0000, i, 2'b00};
      if (!w) begin
        exp_q.push_back(d);
        msk_q.push_back(m);
      end
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0000_0000;
      wait_rdy();
    end
  endtask
  task automatic poll(input logic [7:0] i, input int b);
    int n;
    begin
      n = 0;
      do begin
        xfer(1'b0, i, 32'h0000_0000, 32'h0000_0000);
        n++;
      end while (hrdata[b] !== 1'b1 && n < 5000);
      if (hrdata[b] !== 1'b1) begin
        errors++;
        $display("[ERR] %0t status wait timed out", $time);
        report_and_stop();
      end
    end
  endtask
  task automatic rd_map(input int k);
    logic [23:0] m;
    begin
      m = 24'h80_0001 | (24'h00_0003 << (k - 1));
      xfer(1'b0, `IDX_PHASE_MAP_LOW, {24'h00_0000, m[7:0]}, 32'hffff_ffff);
      xfer(1'b0, `IDX_PHASE_MAP_MID, {24'h00_0000, m[15:8]}, 32'hffff_ffff);
      xfer(1'b0, `IDX_PHASE_MAP_HIGH, {24'h00_0000, m[23:16]}, 32'hffff_ffff);
    end
  endtask
  initial begin
    int k;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, `IDX_CLOCK_CTRL, {27'h000_0000, `RST_CLOCK_CTRL}, 32'hffff_ffff);
    xfer(1'b0, `IDX_CAL_CONFIG, {24'h00_0000, `RST_CAL_CONFIG}, 32'hffff_ffff);
    xfer(1'b0, `IDX_CAL_STATUS, 32'h0000_0000, 32'h0000_0003);
    xfer(1'b1, `IDX_PHASE_MAP_LOW, 32'h0000_0000, 32'h0000_0000);
    xfer(1'b0, `IDX_PHASE_MAP_LOW, 32'h0000_00ff, 32'hffff_ffff);
    xfer(1'b0, 8'h40, 32'h0000_0000, 32'hffff_ffff);
    $display("test reset done");
    seed = xs(seed);
    k = 2 + seed % 14;
    edge_pos <= k[4:0];
    run <= 1'b1;
    poll(`IDX_CAL_STATUS, `STAT_VALID_BIT);
    rd_map(k);
    xfer(1'b1, `IDX_CLOCK_CTRL, 32'h0000_0000, 32'h0000_0000);
    xfer(1'b0, `IDX_CAL_STATUS, 32'h0000_0000, 32'h0000_0002);
    seed = xs(seed);
    k = 2 + seed % 14;
    edge_pos <= k[4:0];
    repeat (120) @(posedge hclk);
    poll(`IDX_CAL_STATUS, `STAT_VALID_BIT);
    rd_map(k);
    $display("test phase map done");
    for (int t = 0; t < 16; t++) begin
      xfer(1'b1, `IDX_CLOCK_CTRL, {28'h000_0001, t[3:0]}, 32'h0000_0000);
      repeat (6) @(posedge hclk);
      chk({31'h0000_0000, sysref_captured}, {31'h0000_0000, t >= k}, 32'h0000_0001);
    end
    // Middle of the usable run below the transition
    xfer(1'b1, `IDX_CLOCK_CTRL, {28'h000_0001, 4'((k - 1) / 2)}, 32'h0000_0000);
    repeat (6) @(posedge hclk);
    chk({31'h0000_0000, sysref_captured}, 32'h0000_0000, 32'h0000_0001);
    xfer(1'b1, `IDX_CLOCK_CTRL, 32'hffff_ffef, 32'h0000_0000);
    xfer(1'b0, `IDX_CAL_STATUS, 32'h0000_0000, 32'h0000_0002);
    xfer(1'b0, `IDX_CLOCK_CTRL, 32'h0000_000f, 32'hffff_ffff);
    $display("test capture tap done");
    xfer(1'b1, `IDX_CLOCK_CTRL, 32'h0000_0010, 32'h0000_0000);
    xfer(1'b1, `IDX_CAL_CONFIG, 32'h0000_0002, 32'h0000_0000);
    xfer(1'b1, `IDX_CAL_ENABLE, 32'h0000_0001, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    xfer(1'b0, `IDX_CAL_STATUS, 32'h0000_0004, 32'h0000_0005);
    poll(`IDX_CAL_STATUS, `STAT_DONE_BIT);
    xfer(1'b0, `IDX_CAL_RESULT, 32'h0001_0122, 32'hffff_ffff);
    chk({15'h0000, clock_invert_delay, coarse_delay, fine_delay}, 32'h0001_0122,
      32'hffff_ffff);
    seed = xs(seed);
    xfer(1'b1, `IDX_CAL_ENABLE, 32'h0000_0000, 32'h0000_0000);
    xfer(1'b1, `IDX_TAD_MANUAL, {15'h0000, seed[16:0]}, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    chk({15'h0000, clock_invert_delay, coarse_delay, fine_delay}, {15'h0000, seed[16:0]},
      32'hffff_ffff);
    xfer(1'b0, `IDX_CAL_RESULT, 32'h0001_0122, 32'hffff_ffff);
    $display("test calibration done");
    report_and_stop();
  end
endmodule
`default_nettype wire
